// ### rtl/udcc_ctrl.sv
module udcc_ctrl
   import udcc_pkg::*;
#(
   parameter int PHY_ERR_CYCLES = PHY_ERR_CYC,
   parameter int RESUME_CYCLES = RESUME_CYC
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   // classic wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [15:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // phy side, asynchronous
   input wire logic phy_clk_in,
   input wire logic phy_receive_valid_in,
   input wire logic phy_receive_active_in,
   // protocol engine queries, same clock
   input wire udcc_pkg::udcc_req_t req_in,
   input wire logic host_wake_enabled_in,
   input wire logic [8:0] rx_fifo_words_in,
   output udcc_pkg::udcc_hshk_t hshk_out,
   output logic setup_to_app_out,
   output logic rx_dma_start_out,
   output logic [8:0] rx_unit_words_out,
   output logic [8:0] burst_words_out,
   output udcc_pkg::udcc_dma_t dma_out,
   output udcc_pkg::udcc_phy_t phy_cfg_out,
   output logic disconnected_out,
   output logic suspend_out,
   output logic phy_error_out,
   output logic resume_signal_out,
   output logic phy_clk_seen_out
);
   import udcc_pkg::*;

   logic [31:0] cfg_q;
   logic [31:0] ctl_q;
   logic hold_q;
   logic phy_err_q;
   logic susp_q;
   logic [31:0] res_cnt_q;
   logic resume_q;
   logic [1:0] rx_sync;
   logic phy_clk_s;
   logic phy_clk_d1_q;
   logic stuck;
   logic req_hit;
   logic wr_cfg;
   logic wr_ctl;
   logic done_wr;
   logic res_wr;
   logic [31:0] bmask;
   logic [31:0] rdata_d;
   logic [31:0] sts;

   assign req_hit = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign bmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
   assign wr_cfg = req_hit && wb_we_in && (wb_adr_in == UDCC_CFG_ADDR);
   assign wr_ctl = req_hit && wb_we_in && (wb_adr_in == UDCC_CTL_ADDR);
   assign done_wr = wr_ctl && wb_sel_in[1] && wb_dat_in[CTL_DONE];
   assign res_wr = wr_ctl && wb_sel_in[0] && wb_dat_in[CTL_RES];

   // ack one cycle after the strobe, dropped the next cycle
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= req_hit;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         cfg_q <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg_q <= (cfg_q & ~(bmask & CFG_WMASK)) | (wb_dat_in & bmask & CFG_WMASK);
      end
   end

   // done bit is write-only: never stored, see hold_q
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         ctl_q <= CTL_RESET;
      end else if (wr_ctl) begin
         ctl_q <= (ctl_q & ~(bmask & CTL_WMASK)) | (wb_dat_in & bmask & CTL_WMASK);
      end
   end

   // status IN hold; a new request in the same cycle as done wins
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         hold_q <= 1'b0;
      end else if (req_in.cfg_status_in && cfg_q[CFG_PRG] && !hold_q) begin
         hold_q <= 1'b1;
      end else if (done_wr) begin
         hold_q <= 1'b0;
      end
   end

   always_comb begin
      rdata_d = 32'h0;
      if (wb_adr_in == UDCC_CFG_ADDR) begin
         rdata_d = cfg_q;
      end else if (wb_adr_in == UDCC_CTL_ADDR) begin
         rdata_d = ctl_q;
      end else if (wb_adr_in == UDCC_STS_ADDR) begin
         rdata_d = sts;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         wb_dat_out <= 32'h0;
      end else if (req_hit && !wb_we_in) begin
         wb_dat_out <= rdata_d;
      end
   end

   assign sts = {15'h0, phy_err_q, 3'h0, susp_q, disconnected_out, hold_q, resume_q, 9'h0};

   // phy inputs cross from the phy domain
   udcc_sync #(.WIDTH(2)) u_rx_sync (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .async_in({phy_receive_valid_in, phy_receive_active_in}),
      .sync_out(rx_sync)
   );

   udcc_sync #(.WIDTH(1)) u_clk_sync (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .async_in(phy_clk_in),
      .sync_out(phy_clk_s)
   );

   // phy clock edge seen: liveness indication only
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         phy_clk_d1_q <= 1'b0;
         phy_clk_seen_out <= 1'b0;
      end else begin
         phy_clk_d1_q <= phy_clk_s;
         phy_clk_seen_out <= phy_clk_s && !phy_clk_d1_q;
      end
   end

   udcc_stuck_timer #(.LIMIT(PHY_ERR_CYCLES), .SHORT(SCALED_CYC)) u_stuck (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .level_in(cfg_q[CFG_PHYERR] && (rx_sync[1] || rx_sync[0])),
      .shrink_in(ctl_q[CTL_SCALE]),
      .expired_out(stuck)
   );

   // error is sticky until the watch is turned off
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         phy_err_q <= 1'b0;
      end else if (stuck) begin
         phy_err_q <= 1'b1;
      end else if (!cfg_q[CFG_PHYERR]) begin
         phy_err_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         susp_q <= 1'b0;
      end else begin
         susp_q <= phy_err_q && !ctl_q[CTL_SD];
      end
   end

   assign suspend_out = susp_q;
   assign phy_error_out = phy_err_q;
   assign disconnected_out = ctl_q[CTL_SD];

   // single resume pulse: only with capability and host permission
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         res_cnt_q <= '0;
         resume_q <= 1'b0;
      end else if (res_wr && cfg_q[CFG_REMOTE_WAKE_CAPABLE] && host_wake_enabled_in && !ctl_q[CTL_SD]) begin
         res_cnt_q <= ctl_q[CTL_SCALE] ? 32'(SCALED_CYC) : 32'(RESUME_CYCLES);
         resume_q <= 1'b1;
      end else if (res_cnt_q > 32'h1) begin
         res_cnt_q <= res_cnt_q - 32'h1;
      end else begin
         res_cnt_q <= '0;
         resume_q <= 1'b0;
      end
   end

   assign resume_signal_out = resume_q;

   // handshake policy, highest priority first
   always_comb begin
      hshk_out = HS_ACK;
      setup_to_app_out = 1'b0;
      if (ctl_q[CTL_SD]) begin
         hshk_out = HS_NAK;
      end else if (req_in.set_desc) begin
         if (cfg_q[CFG_SET_DESC]) begin
            hshk_out = HS_PASS;
            setup_to_app_out = 1'b1;
         end else begin
            hshk_out = HS_STALL;
         end
      end else if (req_in.cfg_status_in) begin
         hshk_out = (cfg_q[CFG_PRG] && (hold_q || !done_wr)) ? HS_NAK : HS_ACK;
      end else if (req_in.ep0_clear_halt) begin
         hshk_out = cfg_q[CFG_HALT] ? HS_STALL : HS_ACK;
      end else if (req_in.status_out_data) begin
         // either bit asks for stall
         hshk_out = (cfg_q[CFG_STAT1] || cfg_q[CFG_STAT0]) ? HS_STALL : HS_ACK;
      end else if (req_in.out_token && ctl_q[CTL_NAK]) begin
         hshk_out = HS_NAK;
      end
   end

   // dma and phy configuration to the datapath
   always_comb begin
      dma_out.dma_mode = ctl_q[CTL_MODE];
      dma_out.tx_dma_run = ctl_q[CTL_MODE] && ctl_q[CTL_TDE];
      dma_out.rx_dma_run = ctl_q[CTL_MODE] && ctl_q[CTL_RDE];
      dma_out.rx_threshold_enable = ctl_q[CTL_THE];
      dma_out.rx_threshold_length = ctl_q[CTL_RX_THRESHOLD_LENGTH_LO +: 8];
      dma_out.burst_split_enable = ctl_q[CTL_BURST_SPLIT_ENABLE];
      dma_out.burst_length_field = ctl_q[CTL_BURST_LENGTH_FIELD_LO +: 8];
      dma_out.buffer_fill_mode = ctl_q[CTL_BF];
      dma_out.big_endian_select = ctl_q[CTL_BE];
      dma_out.descriptor_writeback = ctl_q[CTL_DU];
   end

   assign rx_unit_words_out = {1'b0, ctl_q[CTL_RX_THRESHOLD_LENGTH_LO +: 8]} + 9'h1;
   assign rx_dma_start_out = dma_out.rx_dma_run && (rx_fifo_words_in >= rx_unit_words_out);
   // without split, a single-word burst
   assign burst_words_out = ctl_q[CTL_BURST_SPLIT_ENABLE] ? ({1'b0, ctl_q[CTL_BURST_LENGTH_FIELD_LO +: 8]} + 9'h1) : 9'h1;

   always_comb begin
      phy_cfg_out.ulpi_ddr = cfg_q[CFG_DDR];
      phy_cfg_out.utmi_two_way_bus = cfg_q[CFG_DIR];
      phy_cfg_out.utmi_narrow_width = cfg_q[CFG_PI];
      phy_cfg_out.expected_speed = udcc_speed_t'(cfg_q[CFG_SPD_LO +: 2]);
      // each trim step adds 16 bit times, 7 steps reach 848
      phy_cfg_out.hs_timeout_bits = 10'(HS_BASE_BITS) + {3'h0, cfg_q[CFG_HS_LO +: 3], 4'h0};
      // trim saturates at the 18 bit-time ceiling
      phy_cfg_out.fs_timeout_bits = (cfg_q[CFG_FS_LO +: 3] > 3'h2) ? 5'd18 :
                                    5'(FS_BASE_BITS) + {3'h0, cfg_q[CFG_FS_LO +: 2]};
      phy_cfg_out.sync_frame_support = cfg_q[CFG_SS];
      phy_cfg_out.self_powered = cfg_q[CFG_SP];
      phy_cfg_out.remote_wake_capable = cfg_q[CFG_REMOTE_WAKE_CAPABLE];
      phy_cfg_out.sim_timer_shrink = ctl_q[CTL_SCALE];
   end
endmodule

// ### rtl/udcc_pkg.sv
package udcc_pkg;
   // register byte addresses
   localparam logic [15:0] UDCC_CFG_ADDR = 16'hb000;
   localparam logic [15:0] UDCC_CTL_ADDR = 16'hb004;
   localparam logic [15:0] UDCC_STS_ADDR = 16'hb008;
   // configuration register fields
   localparam int CFG_DDR = 19;
   localparam int CFG_SET_DESC = 18;
   localparam int CFG_PRG = 17;
   localparam int CFG_HALT = 16;
   localparam int CFG_HS_LO = 13;
   localparam int CFG_FS_LO = 10;
   localparam int CFG_PHYERR = 9;
   localparam int CFG_STAT1 = 8;
   localparam int CFG_STAT0 = 7;
   localparam int CFG_DIR = 6;
   localparam int CFG_PI = 5;
   localparam int CFG_SS = 4;
   localparam int CFG_SP = 3;
   localparam int CFG_REMOTE_WAKE_CAPABLE = 2;
   localparam int CFG_SPD_LO = 0;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_WMASK = 32'h000f_ffff;
   // control register fields
   localparam int CTL_RX_THRESHOLD_LENGTH_LO = 24;
   localparam int CTL_BURST_LENGTH_FIELD_LO = 16;
   localparam int CTL_DONE = 13;
   localparam int CTL_NAK = 12;
   localparam int CTL_SCALE = 11;
   localparam int CTL_SD = 10;
   localparam int CTL_MODE = 9;
   localparam int CTL_BURST_SPLIT_ENABLE = 8;
   localparam int CTL_THE = 7;
   localparam int CTL_BF = 6;
   localparam int CTL_BE = 5;
   localparam int CTL_DU = 4;
   localparam int CTL_TDE = 3;
   localparam int CTL_RDE = 2;
   localparam int CTL_RES = 0;
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTL_WMASK = 32'hffff_1ffd;
   // status register fields (own layout)
   localparam int STS_PHYERR = 16;
   localparam int STS_SUSP = 12;
   localparam int STS_DISC = 11;
   localparam int STS_HOLD = 10;
   localparam int STS_RESUME = 9;
   // timing
   localparam int CLK_HZ = 50_000_000;
   localparam int PHY_ERR_US = 2000;
   localparam int PHY_ERR_CYC = PHY_ERR_US * (CLK_HZ / 1_000_000);
   localparam int SCALED_CYC = 64;
   localparam int RESUME_US = 10_000;
   localparam int RESUME_CYC = RESUME_US * (CLK_HZ / 1_000_000);
   localparam int HS_BASE_BITS = 736;
   localparam int FS_BASE_BITS = 16;

   typedef enum logic [1:0] {
      SPD_HS = 2'b00,
      SPD_FS = 2'b01,
      SPD_LS = 2'b10,
      SPD_FS48 = 2'b11
   } udcc_speed_t;

   typedef enum logic [1:0] {
      HS_ACK = 2'b00,
      HS_NAK = 2'b01,
      HS_STALL = 2'b10,
      HS_PASS = 2'b11
   } udcc_hshk_t;

   // request classes the protocol engine asks about
   typedef struct packed {
      logic set_desc;
      logic cfg_status_in;
      logic ep0_clear_halt;
      logic status_out_data;
      logic out_token;
   } udcc_req_t;

   typedef struct packed {
      logic dma_mode;
      logic tx_dma_run;
      logic rx_dma_run;
      logic rx_threshold_enable;
      logic [7:0] rx_threshold_length;
      logic burst_split_enable;
      logic [7:0] burst_length_field;
      logic buffer_fill_mode;
      logic big_endian_select;
      logic descriptor_writeback;
   } udcc_dma_t;

   typedef struct packed {
      logic ulpi_ddr;
      logic utmi_two_way_bus;
      logic utmi_narrow_width;
      udcc_speed_t expected_speed;
      logic [9:0] hs_timeout_bits;
      logic [4:0] fs_timeout_bits;
      logic sync_frame_support;
      logic self_powered;
      logic remote_wake_capable;
      logic sim_timer_shrink;
   } udcc_phy_t;
endpackage

// ### rtl/udcc_sync.sv
module udcc_sync #(
   parameter int WIDTH = 2
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ### rtl/udcc_stuck_timer.sv
// flags when a level stays high for LIMIT cycles (SHORT when shrink_in is set); counter resets on any drop
module udcc_stuck_timer #(
   parameter int LIMIT = 100_000,
   parameter int SHORT = 64
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic level_in,
   input wire logic shrink_in,
   output logic expired_out
);
   logic [31:0] cnt_q;
   logic [31:0] lim;

   assign lim = shrink_in ? 32'(SHORT) : 32'(LIMIT);

   always_ff @(posedge mclk_in) begin
      if (!resetn_in || !level_in) begin
         cnt_q <= '0;
      end else if (cnt_q < lim) begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   assign expired_out = (cnt_q >= lim);
endmodule

// ### sim/udcc_phy_model.sv
module udcc_phy_model (
   input wire logic stuck_in,
   output logic phy_clk_out,
   output logic rx_valid_out,
   output logic rx_active_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] ph_q = 3'h0;
   // phy clock runs free, phase offset from the system clock
   initial begin
      phy_clk_out = 1'b0;
      #37;
      forever #80 phy_clk_out = ~phy_clk_out;
   end
   always_ff @(posedge phy_clk_out) ph_q <= ph_q + 3'h1;
   // short receive bursts, far below the stuck limit
   assign rx_active_out = stuck_in | (ph_q == 3'h7);
   assign rx_valid_out = stuck_in;
endmodule

// ### sim/udcc_ctrl_assertions.sv
module udcc_ctrl_assertions
   import udcc_pkg::*;
#(
   parameter int PHY_ERR_CYCLES = 50,
   parameter int RESUME_CYCLES = 20
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_ack_out,
   input wire logic phy_receive_valid_in,
   input wire logic phy_receive_active_in,
   input wire udcc_pkg::udcc_req_t req_in,
   input wire logic host_wake_enabled_in,
   input wire logic [8:0] rx_fifo_words_in,
   input wire udcc_pkg::udcc_hshk_t hshk_out,
   input wire logic setup_to_app_out,
   input wire logic rx_dma_start_out,
   input wire logic [8:0] rx_unit_words_out,
   input wire logic [8:0] burst_words_out,
   input wire udcc_pkg::udcc_dma_t dma_out,
   input wire udcc_pkg::udcc_phy_t phy_cfg_out,
   input wire logic disconnected_out,
   input wire logic suspend_out,
   input wire logic phy_error_out,
   input wire logic resume_signal_out
);
   int stuck_q;
   int high_q;
   int err_lim;
   int res_lim;
   assign err_lim = phy_cfg_out.sim_timer_shrink ? SCALED_CYC : PHY_ERR_CYCLES;
   assign res_lim = phy_cfg_out.sim_timer_shrink ? SCALED_CYC : RESUME_CYCLES;
   // raw run length; the synced copy lags, so this is never behind
   always_ff @(posedge mclk_in) begin
      if (!resetn_in || !(phy_receive_valid_in || phy_receive_active_in)) stuck_q <= 0;
      else stuck_q <= stuck_q + 1;
   end
   always_ff @(posedge mclk_in) begin
      if (!resetn_in || !resume_signal_out) high_q <= 0;
      else high_q <= high_q + 1;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   bus_ack_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("ack late");
   set_desc_a: assert property (req_in.set_desc && !disconnected_out
      |-> hshk_out == (setup_to_app_out ? HS_PASS : HS_STALL)) else $error("set desc reply");
   disc_nak_a: assert property (disconnected_out && req_in != '0 |-> hshk_out == HS_NAK)
      else $error("no nak while disconnected");
   rx_start_a: assert property (rx_dma_start_out ==
      (dma_out.rx_dma_run && rx_fifo_words_in >= rx_unit_words_out)) else $error("rx start");
   burst_len_a: assert property (burst_words_out ==
      (dma_out.burst_split_enable ? {1'b0, dma_out.burst_length_field} + 9'h1 : 9'h1)) else $error("burst");
   susp_follow_a: assert property (phy_error_out && !disconnected_out |=> suspend_out)
      else $error("no suspend");
   err_after_a: assert property ($rose(phy_error_out) |-> stuck_q >= err_lim)
      else $error("phy error early");
   wake_cause_a: assert property ($rose(resume_signal_out) |-> phy_cfg_out.remote_wake_capable
      && $past(host_wake_enabled_in) && !$past(disconnected_out)) else $error("resume cause");
   wake_len_a: assert property ($fell(resume_signal_out) |-> high_q == res_lim)
      else $error("resume length");
   trim_range_a: assert property (phy_cfg_out.hs_timeout_bits inside {[736:848]}
      && phy_cfg_out.fs_timeout_bits inside {[16:18]}) else $error("timeout range");
endmodule

bind udcc_ctrl udcc_ctrl_assertions #(
   .PHY_ERR_CYCLES(PHY_ERR_CYCLES),
   .RESUME_CYCLES(RESUME_CYCLES)
) u_chk (
   .mclk_in, .resetn_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .phy_receive_valid_in,
   .phy_receive_active_in, .req_in, .host_wake_enabled_in, .rx_fifo_words_in, .hshk_out,
   .setup_to_app_out, .rx_dma_start_out, .rx_unit_words_out, .burst_words_out, .dma_out,
   .phy_cfg_out, .disconnected_out, .suspend_out, .phy_error_out, .resume_signal_out
);

// ### sim/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import udcc_pkg::*;
   localparam int PHY_N = 50;
   localparam int RES_N = 20;
   logic mclk_in = 1'b0, resetn_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
   logic host_wake_enabled_in = 1'b0, stuck = 1'b0;
   logic [15:0] wb_adr_in = 16'h0;
   logic [3:0] wb_sel_in = 4'hf;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd;
   logic [8:0] rx_fifo_words_in = 9'h0, rx_unit_words_out, burst_words_out;
   udcc_req_t req_in = '0;
   udcc_hshk_t hshk_out;
   udcc_dma_t dma_out;
   udcc_phy_t phy_cfg_out;
   logic wb_ack_out, setup_to_app_out, rx_dma_start_out, disconnected_out, suspend_out;
   logic phy_error_out, resume_signal_out, phy_clk_seen_out, phy_clk_in;
   logic phy_receive_valid_in, phy_receive_active_in;
   int n_fail = 0, total_checks = 0, n;
   udcc_ctrl #(.PHY_ERR_CYCLES(PHY_N), .RESUME_CYCLES(RES_N)) DUT (
      .mclk_in, .resetn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
      .wb_dat_out, .wb_ack_out, .phy_clk_in, .phy_receive_valid_in, .phy_receive_active_in, .req_in,
      .host_wake_enabled_in, .rx_fifo_words_in, .hshk_out, .setup_to_app_out, .rx_dma_start_out,
      .rx_unit_words_out, .burst_words_out, .dma_out, .phy_cfg_out, .disconnected_out, .suspend_out,
      .phy_error_out, .resume_signal_out, .phy_clk_seen_out
   );
   udcc_phy_model u_phy (.stuck_in(stuck), .phy_clk_out(phy_clk_in), .rx_valid_out(phy_receive_valid_in),
      .rx_active_out(phy_receive_active_in));
   initial forever #10 mclk_in = ~mclk_in;
   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_dat_in <= d;
      i = 0;
      do begin
         @(posedge mclk_in);
         i++;
      end while (wb_ack_out !== 1'b1 && i < 16);
      chk(wb_ack_out, 1);
      if (wb_ack_out !== 1'b1) finish_test();
      rd = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask
   task rdc(input logic [15:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // comb answer checked one cycle on, after any hold has registered
   task hs(input udcc_req_t r, input udcc_hshk_t e);
      @(posedge mclk_in);
      req_in <= r;
      @(posedge mclk_in);
      @(negedge mclk_in);
      chk(hshk_out, e);
   endtask
   task fifo(input logic [8:0] v, input logic e);
      @(posedge mclk_in);
      rx_fifo_words_in <= v;
      @(negedge mclk_in);
      chk(rx_dma_start_out, e);
   endtask
   task cnt_res(input logic [31:0] e);
      n = 0;
      repeat (40) begin
         @(negedge mclk_in);
         if (resume_signal_out === 1'b1) n++;
      end
      chk(n, e);
   endtask
   initial begin
      repeat (8) @(posedge mclk_in);
      resetn_in <= 1'b1;
      rdc(UDCC_CFG_ADDR, CFG_RESET);
      rdc(UDCC_CTL_ADDR, CTL_RESET);
      rdc(UDCC_STS_ADDR, 32'h0);
      chk({burst_words_out, rx_unit_words_out}, {9'h1, 9'h1});
      chk({phy_cfg_out.hs_timeout_bits, phy_cfg_out.fs_timeout_bits}, {10'd736, 5'd16});
      n = 0;
      repeat (160) begin
         @(posedge mclk_in);
         if (phy_clk_seen_out === 1'b1) n++;
      end
      chk(n >= 19 && n <= 21, 1);
      $display("test reset ended");
      wb(1'b1, UDCC_CFG_ADDR, 32'hffff_ffff);
      rdc(UDCC_CFG_ADDR, 32'h000f_ffff);
      wb(1'b1, 16'hb00c, 32'hffff_ffff);
      rdc(16'hb00c, 32'h0);
      chk({phy_cfg_out.ulpi_ddr, phy_cfg_out.utmi_two_way_bus, phy_cfg_out.utmi_narrow_width}, 3'h7);
      chk({phy_cfg_out.sync_frame_support, phy_cfg_out.self_powered, phy_cfg_out.remote_wake_capable}, 3'h7);
      chk({phy_cfg_out.hs_timeout_bits, phy_cfg_out.fs_timeout_bits}, {10'd848, 5'd18});
      hs(5'b10000, HS_PASS);
      chk(setup_to_app_out, 1);
      hs(5'b00100, HS_STALL);
      hs(5'b00010, HS_STALL);
      hs(5'b00001, HS_ACK);
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, UDCC_CFG_ADDR, i << 7 | i << 10 | i << 13 | i);
         hs(5'b00010, i ? HS_STALL : HS_ACK);
         chk(phy_cfg_out.expected_speed, i);
         chk(phy_cfg_out.hs_timeout_bits, 736 + 16 * i);
         chk(phy_cfg_out.fs_timeout_bits, i > 2 ? 18 : 16 + i);
      end
      hs(5'b10000, HS_STALL);
      chk(setup_to_app_out, 0);
      hs(5'b00100, HS_ACK);
      $display("test config ended");
      wb(1'b1, UDCC_CTL_ADDR, 32'h1234_5bfc);
      rdc(UDCC_CTL_ADDR, 32'h1234_1bfc);
      chk({burst_words_out, rx_unit_words_out}, {9'h35, 9'h13});
      chk({dma_out.dma_mode, dma_out.tx_dma_run, dma_out.rx_dma_run}, 3'h7);
      chk({dma_out.rx_threshold_enable, dma_out.buffer_fill_mode}, 2'h3);
      chk({dma_out.big_endian_select, dma_out.descriptor_writeback}, 2'h3);
      chk(phy_cfg_out.sim_timer_shrink, 1);
      hs(5'b00001, HS_NAK);
      fifo(9'h12, 1'b0);
      fifo(9'h13, 1'b1);
      wb(1'b1, UDCC_CTL_ADDR, 32'h1234_58fc);
      fifo(9'h13, 1'b0);
      chk(burst_words_out, 1);
      $display("test control ended");
      wb(1'b1, UDCC_CTL_ADDR, 32'h0);
      wb(1'b1, UDCC_CFG_ADDR, 32'h0002_0000);
      hs(5'b01000, HS_NAK);
      @(posedge mclk_in);
      req_in <= '0;
      rdc(UDCC_STS_ADDR, 32'h400);
      wb(1'b1, UDCC_CTL_ADDR, 32'h2000);
      rdc(UDCC_STS_ADDR, 32'h0);
      rdc(UDCC_CTL_ADDR, 32'h0);
      $display("test reprogram ended");
      wb(1'b1, UDCC_CFG_ADDR, 32'h4);
      host_wake_enabled_in <= 1'b1;
      wb(1'b1, UDCC_CTL_ADDR, 32'h400);
      wb(1'b1, UDCC_CTL_ADDR, 32'h401);
      cnt_res(0);
      chk(disconnected_out, 1);
      hs(5'b00001, HS_NAK);
      rdc(UDCC_STS_ADDR, 32'h800);
      // leave disconnect first: a resume request in the same write still sees it set
      wb(1'b1, UDCC_CTL_ADDR, 32'h0);
      wb(1'b1, UDCC_CTL_ADDR, 32'h1);
      // first resume cycle passes while the bus task is still closing
      cnt_res(RES_N - 1);
      host_wake_enabled_in <= 1'b0;
      wb(1'b1, UDCC_CTL_ADDR, 32'h1);
      cnt_res(0);
      $display("test wake ended");
      for (int s = 0; s < 2; s++) begin
         wb(1'b1, UDCC_CTL_ADDR, s << 11);
         wb(1'b1, UDCC_CFG_ADDR, 32'h200);
         stuck <= 1'b1;
         repeat ((s ? SCALED_CYC : PHY_N) - 10) @(posedge mclk_in);
         chk(phy_error_out, 0);
         repeat (20) @(posedge mclk_in);
         chk(phy_error_out, 1);
         rdc(UDCC_STS_ADDR, 32'h0001_1000);
         chk(suspend_out, 1);
         stuck <= 1'b0;
         wb(1'b1, UDCC_CFG_ADDR, 32'h0);
         // timer output stays expired one more edge after the synced level drops
         repeat (2) @(posedge mclk_in);
         chk(phy_error_out, 0);
      end
      $display("test phy error ended");
      finish_test();
   end
endmodule
